// >>> src/fit_pkg.sv
package fit_pkg;
  // counter width
  localparam int FIT_CW = 32;
  // mode codes
  localparam logic [3:0] FIT_M_EVENT = 4'h1;
  localparam logic [3:0] FIT_M_PERIOD = 4'h2;
  localparam logic [3:0] FIT_M_WIDTH = 4'h3;
  localparam logic [3:0] FIT_M_SGATED = 4'h4;
  localparam logic [3:0] FIT_M_STRIG = 4'h5;
  localparam logic [3:0] FIT_M_RETRIG = 4'h6;
  localparam logic [3:0] FIT_M_CTRIG = 4'h7;
  localparam logic [3:0] FIT_M_CGATED = 4'h8;
  // reset value and unit step
  localparam logic [31:0] FIT_ZERO = 32'h00000000;
  localparam logic [31:0] FIT_ONE = 32'h00000001;
  // internal count clock rate and time base
  localparam int FIT_MCLK_MHZ = 100;
  localparam int FIT_INT_MHZ = 80;
  // operating states, gray order along the usual path
  typedef enum logic [2:0] {
    FIT_ST_IDLE = 3'b000,
    FIT_ST_ARM = 3'b001,
    FIT_ST_RUN = 3'b011,
    FIT_ST_PULSE = 3'b010,
    FIT_ST_DONE = 3'b110
  } fit_state_e;
endpackage : fit_pkg

// >>> src/fit_edge_if.sv
`timescale 1ns/100ps
// qualified input events passed from the conditioner to the core
interface fit_edge_if;
  logic clk_evt;
  logic gate_lvl;
  logic gate_rise;
  logic gate_fall;
  logic dir_up;
  modport src (output clk_evt, gate_lvl, gate_rise, gate_fall, dir_up);
  modport dst (input clk_evt, gate_lvl, gate_rise, gate_fall, dir_up);
endinterface : fit_edge_if

// >>> src/fit_cond.sv
`timescale 1ns/100ps
// synchronises pins, applies polarity and source selection, finds edges
module fit_cond
  import fit_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // raw pins
  input wire logic clk_pin,
  input wire logic gate_pin,
  input wire logic dir_pin,
  // configuration
  input wire logic clk_ext_sel,
  input wire logic clk_inv,
  input wire logic gate_sw_sel,
  input wire logic gate_sw_lvl,
  input wire logic gate_inv,
  input wire logic dir_sw_sel,
  input wire logic dir_sw_up,
  input wire logic dir_inv,
  // events out
  fit_edge_if.src ev
);
  // two-stage synchronisers for the three pins
  logic [2:0] s1_r, s1_nxt, s2_r, s2_nxt;
  // previous qualified levels for edge finding
  logic clk_q_r, clk_q_nxt, gate_q_r, gate_q_nxt;
  // internal time base phase accumulator
  logic [7:0] acc_r, acc_nxt;
  logic tick;
  logic clk_lvl, gate_lvl;

  // next state of synchronisers, accumulator and edge history
  always_comb
  begin
    s1_nxt = {dir_pin, gate_pin, clk_pin};
    s2_nxt = s1_r;
    // internal clock: 80 ticks per 100 mclk cycles
    if ({1'b0, acc_r} + 9'(FIT_INT_MHZ) >= 9'(FIT_MCLK_MHZ))
    begin
      acc_nxt = 8'(acc_r + 8'(FIT_INT_MHZ) - 8'(FIT_MCLK_MHZ));
      tick = 1'b1;
    end
    else
    begin
      acc_nxt = 8'(acc_r + 8'(FIT_INT_MHZ));
      tick = 1'b0;
    end
    clk_lvl = s2_r[0] ^ clk_inv;
    gate_lvl = gate_sw_sel ? gate_sw_lvl : (s2_r[1] ^ gate_inv);
    clk_q_nxt = clk_lvl;
    gate_q_nxt = gate_lvl;
  end

  // registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      clk_q_r <= 1'b0;
      gate_q_r <= 1'b0;
      acc_r <= 8'h00;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      clk_q_r <= clk_q_nxt;
      gate_q_r <= gate_q_nxt;
      acc_r <= acc_nxt;
    end
  end

  assign ev.clk_evt = clk_ext_sel ? (clk_lvl & ~clk_q_r) : tick;
  assign ev.gate_lvl = gate_lvl;
  assign ev.gate_rise = gate_lvl & ~gate_q_r;
  assign ev.gate_fall = ~gate_lvl & gate_q_r;
  assign ev.dir_up = dir_sw_sel ? dir_sw_up : (s2_r[2] ^ dir_inv);
endmodule : fit_cond

// >>> src/fit_top.sv
`timescale 1ns/100ps
module fit_top
  import fit_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // static digital pins
  input wire logic static_in_0,
  input wire logic static_in_1,
  input wire logic static_in_2,
  input wire logic static_in_3,
  output logic static_out_0,
  output logic static_out_1,
  // software static io
  input wire logic [1:0] sw_static_out,
  output logic [3:0] sw_static_in,
  // timer mode of the output pins
  input wire logic tc_out_en,
  // source and polarity selects
  input wire logic clk_ext_sel,
  input wire logic clk_inv,
  input wire logic gate_sw_sel,
  input wire logic gate_sw_lvl,
  input wire logic gate_inv,
  input wire logic dir_sw_sel,
  input wire logic dir_sw_up,
  input wire logic dir_inv,
  input wire logic out_inv,
  // mode and counts
  input wire logic [3:0] mode,
  input wire logic [31:0] init_count,
  input wire logic [31:0] delay_count,
  input wire logic [31:0] width_count,
  // commands, one-cycle pulses
  input wire logic sw_start,
  input wire logic sw_reset,
  // status
  output logic [31:0] count_value,
  output logic tc_done,
  output logic tc_running
);
  fit_edge_if ev ();

  // pins 0..2 feed the timer inputs
  fit_cond u_cond (
    .mclk(mclk),
    .arst_n(arst_n),
    .clk_pin(static_in_0),
    .gate_pin(static_in_2),
    .dir_pin(static_in_1),
    .clk_ext_sel(clk_ext_sel),
    .clk_inv(clk_inv),
    .gate_sw_sel(gate_sw_sel),
    .gate_sw_lvl(gate_sw_lvl),
    .gate_inv(gate_inv),
    .dir_sw_sel(dir_sw_sel),
    .dir_sw_up(dir_sw_up),
    .dir_inv(dir_inv),
    .ev(ev)
  );

  // step the count by one in the chosen direction
  function automatic logic [FIT_CW-1:0] fit_step(
    input logic [FIT_CW-1:0] v, input logic up);
    fit_step = up ? FIT_CW'(v + FIT_ONE) : FIT_CW'(v - FIT_ONE);
  endfunction : fit_step

  // state of the counter engine
  fit_state_e st_r, st_nxt;
  logic [3:0] mode_r, mode_nxt;          // latched mode
  logic [31:0] cnt_r, cnt_nxt;           // the count
  logic [31:0] init_r, init_nxt;         // latched initial count
  logic [31:0] dly_r, dly_nxt;           // latched delay
  logic [31:0] wid_r, wid_nxt;           // latched width
  logic [31:0] ph_r, ph_nxt;             // phase counter for pulses
  logic pulse_r, pulse_nxt;              // raw output level
  logic done_r, done_nxt;                // measurement complete
  logic [1:0] so_r, so_nxt;              // static outputs
  logic [3:0] si_r, si_nxt;              // sampled static inputs
  logic [31:0] cv_r, cv_nxt;             // readable count copy
  logic o0_r, o0_nxt, o1_r, o1_nxt;
  logic gen_mode, cont_mode;

  // next values of the engine
  always_comb
  begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    init_nxt = init_r;
    dly_nxt = dly_r;
    wid_nxt = wid_r;
    ph_nxt = ph_r;
    pulse_nxt = pulse_r;
    done_nxt = done_r;
    gen_mode = (mode_r >= FIT_M_SGATED);
    cont_mode = (mode_r == FIT_M_CTRIG) || (mode_r == FIT_M_CGATED);
    if (sw_reset)
    begin
      st_nxt = FIT_ST_IDLE;
      cnt_nxt = init_r;
      ph_nxt = FIT_ZERO;
      pulse_nxt = 1'b0;
      done_nxt = 1'b0;
    end
    else if (sw_start)
    begin
      mode_nxt = mode;
      init_nxt = init_count;
      dly_nxt = delay_count;
      wid_nxt = width_count;
      cnt_nxt = init_count;
      ph_nxt = FIT_ZERO;
      pulse_nxt = 1'b0;
      done_nxt = 1'b0;
      st_nxt = FIT_ST_ARM;
    end
    else
    begin
      unique case (st_r)
        FIT_ST_IDLE, FIT_ST_DONE:
        begin
        end
        FIT_ST_ARM:
        begin
          unique case (mode_r)
            FIT_M_PERIOD:
              if (ev.gate_rise)
                st_nxt = FIT_ST_RUN;
            FIT_M_WIDTH:
              if (ev.gate_lvl)
                st_nxt = FIT_ST_RUN;
            FIT_M_STRIG, FIT_M_RETRIG, FIT_M_CTRIG:
              if (ev.gate_rise)
                st_nxt = FIT_ST_RUN;
            default:
              st_nxt = FIT_ST_RUN;
          endcase
        end
        FIT_ST_RUN, FIT_ST_PULSE:
        begin
          unique case (mode_r)
            FIT_M_PERIOD:
            begin
              if (ev.gate_rise)
              begin
                done_nxt = 1'b1;
                pulse_nxt = 1'b1;
                st_nxt = FIT_ST_DONE;
              end
              else if (ev.clk_evt)
                cnt_nxt = fit_step(cnt_r, ev.dir_up);
            end
            FIT_M_WIDTH:
            begin
              if (!ev.gate_lvl)
              begin
                done_nxt = 1'b1;
                pulse_nxt = 1'b1;
                st_nxt = FIT_ST_DONE;
              end
              else if (ev.clk_evt)
                cnt_nxt = fit_step(cnt_r, ev.dir_up);
            end
            FIT_M_EVENT:
              if (ev.clk_evt && ev.gate_lvl)
                cnt_nxt = fit_step(cnt_r, ev.dir_up);
            default:
            begin
              if (ev.clk_evt && (ev.gate_lvl ||
                  !(mode_r == FIT_M_SGATED || mode_r == FIT_M_CGATED)))
              begin
                cnt_nxt = fit_step(cnt_r, ev.dir_up);
                ph_nxt = FIT_CW'(ph_r + FIT_ONE);
                if (st_r == FIT_ST_RUN && ph_r + FIT_ONE >= dly_r)
                begin
                  st_nxt = FIT_ST_PULSE;
                  pulse_nxt = 1'b1;
                  ph_nxt = FIT_ZERO;
                end
                else if (st_r == FIT_ST_PULSE && ph_r + FIT_ONE >= wid_r)
                begin
                  pulse_nxt = 1'b0;
                  ph_nxt = FIT_ZERO;
                  if (cont_mode)
                    st_nxt = FIT_ST_RUN;
                  else if (mode_r == FIT_M_RETRIG)
                    st_nxt = FIT_ST_ARM;
                  else
                    st_nxt = FIT_ST_DONE;
                end
              end
            end
          endcase
          if (!gen_mode && st_r == FIT_ST_PULSE)
            st_nxt = FIT_ST_DONE;
        end
        default:
          st_nxt = FIT_ST_IDLE;
      endcase
    end
    so_nxt = sw_static_out;
    si_nxt = {static_in_3, static_in_2, static_in_1, static_in_0};
    cv_nxt = cnt_nxt;
    o0_nxt = tc_out_en ? (pulse_nxt ^ out_inv) : so_nxt[0];
    o1_nxt = tc_out_en ? (done_nxt ^ out_inv) : so_nxt[1];
  end

  // registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= FIT_ST_IDLE;
      mode_r <= FIT_M_EVENT;
      cnt_r <= FIT_ZERO;
      init_r <= FIT_ZERO;
      dly_r <= FIT_ZERO;
      wid_r <= FIT_ZERO;
      ph_r <= FIT_ZERO;
      pulse_r <= 1'b0;
      done_r <= 1'b0;
      so_r <= 2'h0;
      si_r <= 4'h0;
      cv_r <= FIT_ZERO;
      o0_r <= 1'b0;
      o1_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      init_r <= init_nxt;
      dly_r <= dly_nxt;
      wid_r <= wid_nxt;
      ph_r <= ph_nxt;
      pulse_r <= pulse_nxt;
      done_r <= done_nxt;
      so_r <= so_nxt;
      si_r <= si_nxt;
      cv_r <= cv_nxt;
      o0_r <= o0_nxt;
      o1_r <= o1_nxt;
    end
  end

  // outputs straight from flops, except tc_running, which is decoded from st_r
  assign static_out_0 = o0_r;
  assign static_out_1 = o1_r;
  assign sw_static_in = si_r;
  assign count_value = cv_r;
  assign tc_done = done_r;
  assign tc_running = (st_r != FIT_ST_IDLE) && (st_r != FIT_ST_DONE);
endmodule : fit_top

// >>> test/fit_top_monitor.sv
`timescale 1ns/100ps
// watches the top ports of the timer block
module fit_top_monitor
  import fit_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // pins and static io
  input wire logic static_in_0,
  input wire logic static_in_1,
  input wire logic static_in_2,
  input wire logic static_in_3,
  input wire logic static_out_0,
  input wire logic static_out_1,
  input wire logic [1:0] sw_static_out,
  input wire logic [3:0] sw_static_in,
  // config and commands
  input wire logic tc_out_en,
  input wire logic gate_sw_sel,
  input wire logic gate_sw_lvl,
  input wire logic gate_inv,
  input wire logic [3:0] mode,
  input wire logic [31:0] init_count,
  input wire logic sw_start,
  input wire logic sw_reset,
  // status
  input wire logic [31:0] count_value,
  input wire logic tc_done,
  input wire logic tc_running
);
  // pins gathered for sampling
  logic [3:0] pins;
  assign pins = {static_in_3, static_in_2, static_in_1, static_in_0};
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // no command this cycle
  sequence quiet;
    !sw_start && !sw_reset;
  endsequence
  // event mode with software gate held inactive
  sequence gate_off;
    mode == FIT_M_EVENT && gate_sw_sel && !gate_sw_lvl && !gate_inv
      && !sw_start && !sw_reset;
  endsequence
  AST_START_LOAD: assert property (sw_start && !sw_reset |=>
    count_value == $past(init_count)) else $error("count not loaded");
  AST_RESET_HALT: assert property (sw_reset |=>
    !tc_running && !tc_done) else $error("reset did not halt");
  AST_IDLE_HOLD: assert property (!tc_running ##0 quiet |=>
    $stable(count_value)) else $error("idle count moved");
  AST_STEP_ONE: assert property (quiet ##0 mode == FIT_M_EVENT |=>
    (count_value - $past(count_value)) inside
    {32'h0, 32'h1, 32'hFFFFFFFF}) else $error("count jumped");
  AST_GATE_HOLD: assert property (gate_off [*6] |->
    $stable(count_value)) else $error("counted with gate off");
  AST_OUT0_SW: assert property (!tc_out_en |=>
    static_out_0 == $past(sw_static_out[0])) else $error("out0 wrong");
  AST_OUT1_SW: assert property (!tc_out_en |=>
    static_out_1 == $past(sw_static_out[1])) else $error("out1 wrong");
  AST_PIN_SAMPLE: assert property (1'b1 |=>
    sw_static_in == $past(pins)) else $error("input sample wrong");
  AST_DONE_HOLD: assert property (tc_done ##0 quiet |=>
    tc_done) else $error("done dropped");
endmodule : fit_top_monitor
bind fit_top fit_top_monitor u_mon (.*);

// >>> test/fit_pins.sv
`timescale 1ns/100ps
// external signal sources: count clock, direction and gate pins
module fit_pins (
  // clock
  input wire logic mclk,
  // pins toward the block
  output logic clk_pin,
  output logic dir_pin,
  output logic gate_pin
);
  initial
  begin
    clk_pin = 1'b0;
    dir_pin = 1'b1;
    gate_pin = 1'b0;
  end
  // ten mclk per period keeps within 10 MHz
  task automatic clocks(input int n);
    repeat (n)
    begin
      repeat (5) @(posedge mclk);
      #1 clk_pin = 1'b1;
      repeat (5) @(posedge mclk);
      #1 clk_pin = 1'b0;
    end
  endtask : clocks
  // gate level change, well apart from clock edges
  task automatic gate(input logic v);
    repeat (8) @(posedge mclk);
    #1 gate_pin = v;
    repeat (8) @(posedge mclk);
    #1;
  endtask : gate
  // direction level
  task automatic dir(input logic v);
    dir_pin = v;
  endtask : dir
endmodule : fit_pins

// >>> test/fit_top_tb.sv
`timescale 1ns/100ps
module fit_top_tb;
  import fit_pkg::*;
  // design side signals
  logic mclk, arst_n, static_in_0, static_in_1, static_in_2, static_in_3;
  logic static_out_0, static_out_1, tc_out_en, clk_ext_sel, clk_inv;
  logic gate_sw_sel, gate_sw_lvl, gate_inv, dir_sw_sel, dir_sw_up;
  logic dir_inv, out_inv, sw_start, sw_reset, tc_done, tc_running, o0_q;
  logic [1:0] sw_static_out, chk;
  logic [3:0] sw_static_in, mode;
  logic [31:0] init_count, delay_count, width_count, count_value;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int n_checks = 0;
  int npulse = 0;
  fit_top DUT (.*);
  fit_pins u_pins (.mclk(mclk), .clk_pin(static_in_0),
    .dir_pin(static_in_1), .gate_pin(static_in_2));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // random static pin and software outputs every cycle
  always @(posedge mclk)
  begin
    #1;
    {static_in_3, sw_static_out} = 3'($urandom);
  end
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic cmp32(input logic [31:0] got);
    logic [31:0] e;
    e = exp_q.pop_front();
    n_checks++;
    if (got !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, e);
    end
  endtask : cmp32
  task automatic cmp1(input logic got);
    logic [31:0] e;
    e = exp_q.pop_front();
    n_checks++;
    if (got !== e[0])
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, e[0]);
    end
  endtask : cmp1
  // result watcher: pulse counting and queued comparisons
  always @(negedge mclk)
  begin
    npulse += int'(static_out_0 & ~o0_q);
    o0_q = static_out_0;
    if (chk == 2'h1) cmp32(count_value);
    if (chk == 2'h2) cmp32(npulse > 3 ? 32'h3 : 32'(npulse));
    if (chk == 2'h3) cmp1(tc_done);
  end
  task automatic note(input logic [31:0] v, input logic [1:0] k);
    exp_q.push_back(v);
    chk = k;
    @(posedge mclk);
    #1 chk = 2'h0;
  endtask : note
  task automatic start(input logic [3:0] m);
    mode = m;
    init_count = $urandom;
    sw_start = 1'b1;
    @(posedge mclk);
    #1 sw_start = 1'b0;
    npulse = 0;
  endtask : start
  task automatic sreset();
    sw_reset = 1'b1;
    @(posedge mclk);
    #1 sw_reset = 1'b0;
  endtask : sreset
  // measurement: four clocks inside the gate interval
  task automatic meas(input logic [3:0] m);
    start(m);
    u_pins.gate(1'b1);
    u_pins.clocks(4);
    u_pins.gate(1'b0);
    if (m == FIT_M_PERIOD) u_pins.gate(1'b1);
    note(init_count + 32'h4, 2'h1);
    note(32'h1, 2'h3);
    sreset();
    u_pins.gate(1'b0);
  endtask : meas
  // pulse run: two gate pin pulses, then pulse count saturated at 3
  task automatic run(input logic [3:0] m, input logic s, input logic l,
    input logic [31:0] e);
    gate_sw_sel = s;
    gate_sw_lvl = l;
    delay_count = 32'($urandom_range(4, 1));
    width_count = 32'($urandom_range(4, 1));
    start(m);
    repeat (2)
    begin
      u_pins.gate(1'b1);
      u_pins.gate(1'b0);
    end
    note(e, 2'h2);
    sreset();
  endtask : run
  initial
  begin
    void'($urandom(32'h923DAE68));
    {arst_n, sw_start, sw_reset, chk, o0_q} = 6'h0;
    {tc_out_en, clk_inv, gate_inv, dir_inv, out_inv} = 5'h0;
    {clk_ext_sel, gate_sw_sel, gate_sw_lvl, dir_sw_sel, dir_sw_up} = 5'h1F;
    {mode, init_count} = {4'h1, 32'h0};
    {delay_count, width_count} = {32'h2, 32'h2};
    repeat (6) @(posedge mclk);
    #1 arst_n = 1'b1;
    start(FIT_M_EVENT);
    note(init_count, 2'h1);
    u_pins.clocks(3);
    note(init_count + 32'h3, 2'h1);
    gate_sw_lvl = 1'b0;
    u_pins.clocks(3);
    note(init_count + 32'h3, 2'h1);
    {gate_sw_lvl, dir_sw_up} = 2'b10;
    u_pins.clocks(5);
    note(init_count - 32'h2, 2'h1);
    {dir_sw_sel, dir_inv} = 2'b01;
    u_pins.clocks(2);
    note(init_count - 32'h4, 2'h1);
    sreset();
    u_pins.clocks(2);
    note(init_count, 2'h1);
    {dir_sw_sel, dir_sw_up, dir_inv, gate_sw_sel} = 4'b1100;
    meas(FIT_M_WIDTH);
    meas(FIT_M_PERIOD);
    {tc_out_en, clk_ext_sel} = 2'b10;
    run(FIT_M_SGATED, 1'b1, 1'b1, 32'h1);
    run(FIT_M_SGATED, 1'b1, 1'b0, 32'h0);
    run(FIT_M_STRIG, 1'b0, 1'b0, 32'h1);
    run(FIT_M_RETRIG, 1'b0, 1'b0, 32'h2);
    run(FIT_M_CTRIG, 1'b0, 1'b0, 32'h3);
    run(FIT_M_CGATED, 1'b1, 1'b1, 32'h3);
    run(FIT_M_CGATED, 1'b1, 1'b0, 32'h0);
    repeat (2) @(posedge mclk);
    wrap_up();
  end
  // watchdog, far beyond the several hundred cycles of the run
  initial
  begin
    #100us;
    err_count++;
    wrap_up();
  end
endmodule : fit_top_tb
